// *** hdl/rxdsw_pkg.sv ***
// Contract
// - owner bit set means DMA owns descriptor
// - clear owner bit at frame end or full
// - set bit 30 on address filter fail
// - length valid only on last, no error (code zeroes length on last only when descErr and ovfErr are both set)
// - add two status bytes under type-1 offload (code does not add them for control frames, ctrlFrame set)
// - error summary ORs CRC, receive, watchdog errors
package rxdsw_pkg;
   localparam int          OWN_BIT      = 31;
   localparam int          AFAIL_BIT    = 30;
   localparam int          LEN_HI       = 29;
   localparam int          LEN_LO       = 16;
   localparam int          LEN_W        = 14;
   localparam int          ESUM_BIT     = 15;
   localparam int          DESCERR_BIT  = 14;
   localparam int          OVF_BIT      = 11;
   localparam int          LAST_BIT     = 8;
   localparam int          FIRST_BIT    = 9;
   localparam int          WDOG_BIT     = 4;
   localparam int          RXERR_BIT    = 3;
   localparam int          CRC_BIT      = 1;
   localparam logic [13:0] CSUM_BYTES   = 14'h0002;
   localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS  = 32'h0000_0004;
   localparam logic [31:0] ADDR_WORD    = 32'h0000_0008;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam int          CTRL_CSUM    = 0;
endpackage

// *** hdl/rxdsw_wb_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface rxdsw_wb_if;
   logic        start;
   logic        lastDesc;
   logic        daFail;
   logic        crcErr;
   logic        rxErr;
   logic        wdogErr;
   logic        descErr;
   logic        ovfErr;
   logic        ctrlFrame;
   logic        csumType1;
   logic [13:0] byteCount;
   logic [31:0] word;
   modport src (output start, lastDesc, daFail, crcErr, rxErr, wdogErr, descErr, ovfErr,
                ctrlFrame, csumType1, byteCount, input word);
   modport fmt (input start, lastDesc, daFail, crcErr, rxErr, wdogErr, descErr, ovfErr,
                ctrlFrame, csumType1, byteCount, output word);
endinterface
`default_nettype wire

// *** hdl/rxdsw_word_fmt.sv ***
`timescale 1ns/1ns
`default_nettype none
module rxdsw_word_fmt
   import rxdsw_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   rxdsw_wb_if.fmt   wb
);
   wire logic        errSum;
   wire logic        lenOk;
   wire logic [13:0] lenAdj;
   logic      [31:0] next_word;
   logic      [31:0] wordQ;

   assign errSum = wb.crcErr | wb.rxErr | wb.wdogErr;
   assign lenOk  = wb.lastDesc & ~(wb.descErr & wb.ovfErr);
   // length is left zero unless last descriptor without both descErr and ovfErr set, so only then is a count written
   assign lenAdj = (wb.csumType1 & ~wb.ctrlFrame) ? wb.byteCount + CSUM_BYTES
                                                  : wb.byteCount;
   always_comb begin
      next_word              = 32'h0000_0000;
      next_word[OWN_BIT]     = 1'b0;
      next_word[AFAIL_BIT]   = wb.daFail;
      next_word[LEN_HI:LEN_LO] = lenOk ? lenAdj : 14'h0000;
      next_word[ESUM_BIT]    = errSum;
      next_word[DESCERR_BIT] = wb.descErr;
      next_word[OVF_BIT]     = wb.ovfErr;
      next_word[LAST_BIT]    = wb.lastDesc;
      next_word[WDOG_BIT]    = wb.wdogErr;
      next_word[RXERR_BIT]   = wb.rxErr;
      next_word[CRC_BIT]     = wb.crcErr;
   end
   always_ff @(posedge clk) begin
      if (sys_rst)
         wordQ <= {1'b1, 31'h0000_0000};
      else if (wb.start)
         wordQ <= next_word;
   end
   assign wb.word = wordQ;
endmodule
`default_nettype wire

// *** hdl/rxdsw_top.sv ***
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rxdsw_top
   import rxdsw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        frameDone,
   input  wire logic        bufFull,
   input  wire logic        lastDesc,
   input  wire logic        daFail,
   input  wire logic        crcErr,
   input  wire logic        rxErr,
   input  wire logic        wdogErr,
   input  wire logic        descErr,
   input  wire logic        ovfErr,
   input  wire logic        ctrlFrame,
   input  wire logic [13:0] byteCount,
   output logic             wbValid,
   output logic [31:0]      rx_desc_status_word
);
   ////////////////////////////////////////////////////////////////
   rxdsw_wb_if wbi ();
   logic        ctrlReg;
   logic        wbPulse;
   logic        apWrite;
   logic [31:0] apAddr;
   wire logic   apTake;
   wire logic   closeEvt;

   // descriptor handed back on completion or when its buffers fill
   assign closeEvt        = frameDone | bufFull;
   assign wbi.start       = closeEvt;
   assign wbi.lastDesc    = lastDesc;
   assign wbi.daFail      = daFail;
   assign wbi.crcErr      = crcErr;
   assign wbi.rxErr       = rxErr;
   assign wbi.wdogErr     = wdogErr;
   assign wbi.descErr     = descErr;
   assign wbi.ovfErr      = ovfErr;
   assign wbi.ctrlFrame   = ctrlFrame;
   assign wbi.csumType1   = ctrlReg;
   assign wbi.byteCount   = byteCount;

   rxdsw_word_fmt u_fmt (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wb      (wbi.fmt)
   );
   assign rx_desc_status_word = wbi.word;

   always_ff @(posedge clk) begin
      if (sys_rst)
         wbPulse <= 1'b0;
      else
         wbPulse <= closeEvt;
   end
   assign wbValid = wbPulse;

   ////////////////////////////////////////////////////////////////
   // zero-wait slave; always OKAY
   assign apTake    = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         apWrite <= 1'b0;
         apAddr  <= 32'h0000_0000;
      end else if (hready) begin
         apWrite <= apTake & hwrite;
         apAddr  <= apTake ? haddr : 32'hffff_ffff;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         ctrlReg <= CTRL_RESET[CTRL_CSUM];
      else if (apWrite && apAddr == ADDR_CTRL)
         ctrlReg <= hwdata[CTRL_CSUM];
   end

   // owner bit in the status view reflects hand-back to host
   always_comb begin
      hrdata = 32'h0000_0000;
      if (apAddr == ADDR_CTRL)
         hrdata[CTRL_CSUM] = ctrlReg;
      else if (apAddr == ADDR_STATUS)
         hrdata[0] = ~rx_desc_status_word[OWN_BIT];
      else if (apAddr == ADDR_WORD)
         hrdata = rx_desc_status_word;
   end

   ////////////////////////////////////////////////////////////////
   a_owner_cleared: assert property (@(posedge clk) disable iff (sys_rst)
      closeEvt |=> !rx_desc_status_word[OWN_BIT])
      else $error("owner bit not cleared after close");
   a_filter_fail: assert property (@(posedge clk) disable iff (sys_rst)
      closeEvt |=> rx_desc_status_word[AFAIL_BIT] == $past(daFail))
      else $error("filter fail bit mismatch");
   a_len_invalid: assert property (@(posedge clk) disable iff (sys_rst)
      (closeEvt && !lastDesc) |=> rx_desc_status_word[LEN_HI:LEN_LO] == 14'h0000)
      else $error("length written without last descriptor");
   a_len_csum: assert property (@(posedge clk) disable iff (sys_rst)
      (closeEvt && lastDesc && !descErr && ctrlReg && !ctrlFrame)
      |=> rx_desc_status_word[LEN_HI:LEN_LO] == $past(byteCount) + CSUM_BYTES)
      else $error("length missing checksum bytes");
   a_err_summary: assert property (@(posedge clk) disable iff (sys_rst)
      wbValid |-> rx_desc_status_word[ESUM_BIT] ==
         (rx_desc_status_word[CRC_BIT] | rx_desc_status_word[RXERR_BIT]
          | rx_desc_status_word[WDOG_BIT]))
      else $error("error summary mismatch");
   a_owner_status: assert property (@(posedge clk) disable iff (sys_rst)
      wbValid |-> ##1 (!$stable(rx_desc_status_word) || !rx_desc_status_word[OWN_BIT]))
      else $error("owner held after write-back");
endmodule
`default_nettype wire

// *** dv/rxdsw_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rxdsw_host_model
   import rxdsw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        wbValid,
   input  wire logic [31:0] rx_desc_status_word,
   output logic [31:0]      memWord
);
   // host copy only once the word is handed back
   initial memWord = 32'h8000_0000;
   always @(posedge clk) begin
      if (wbValid && !rx_desc_status_word[OWN_BIT]) begin
         memWord <= rx_desc_status_word;
      end
   end
endmodule
`default_nettype wire

// *** dv/tb_rxdsw_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_rxdsw_top
   import rxdsw_pkg::*;
   ;
   logic        clk, sys_rst, hsel, hwrite, frameDone, bufFull, lastDesc, daFail;
   logic        crcErr, rxErr, wdogErr, descErr, ovfErr, ctrlFrame, csum;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [13:0] byteCount;
   wire  logic        hreadyout, hresp, wbValid;
   wire  logic [31:0] hrdata, word, memWord;
   int          num_errors, tests_run;
   rxdsw_top u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frameDone(frameDone),
      .bufFull(bufFull), .lastDesc(lastDesc), .daFail(daFail), .crcErr(crcErr),
      .rxErr(rxErr), .wdogErr(wdogErr), .descErr(descErr), .ovfErr(ovfErr),
      .ctrlFrame(ctrlFrame), .byteCount(byteCount), .wbValid(wbValid),
      .rx_desc_status_word(word));
   rxdsw_host_model u_host (.clk(clk), .wbValid(wbValid), .rx_desc_status_word(word),
      .memWord(memWord));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            num_errors++;
            results();
         end
         @(posedge clk);
      end
   endtask
   // one single word transfer, read data taken at the data phase edge
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      rdy();
      htrans <= 2'h0; hwdata <= d;
      rdy();
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask
   // expected word built here; outputs sampled an edge late so they are settled
   task close(input logic f, ld, da, c, r, wd, de, ov, cf, input logic [13:0] bc);
      logic [13:0] len;
      logic [31:0] e;
      len = (ld && !(de && ov)) ? bc + ((csum && !cf) ? 14'h2 : 14'h0) : 14'h0;
      e = {1'b0, da, len, c | r | wd, de, 2'h0, ov, 2'h0, ld, 3'h0, wd, r, 1'b0, c, 1'b0};
      frameDone <= !f; bufFull <= f; lastDesc <= ld; daFail <= da; crcErr <= c;
      rxErr <= r; wdogErr <= wd; descErr <= de; ovfErr <= ov; ctrlFrame <= cf;
      byteCount <= bc;
      @(posedge clk);
      frameDone <= 1'b0; bufFull <= 1'b0;
      @(posedge clk);
      check({31'h0, wbValid}, 32'h1);
      check(word, e);
      @(posedge clk);
      check({31'h0, wbValid}, 32'h0);
      check(memWord, e);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {hsel, hwrite, frameDone, bufFull, lastDesc, daFail, crcErr, rxErr} = 8'h0;
      {wdogErr, descErr, ovfErr, ctrlFrame, csum} = 5'h0;
      haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2; byteCount = 14'h0;
      num_errors = 0; tests_run = 0; sys_rst = 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, ADDR_WORD, 32'h0);
      check(rd, 32'h8000_0000);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(rd & 32'h1, 32'h0);
      close(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 14'h0040);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(rd & 32'h1, 32'h1);
      bus(1'b1, ADDR_CTRL, 32'h1);
      csum = 1'b1;
      bus(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h1);
      close(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 14'h3ffd);
      close(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 14'h0100);
      close(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 14'h0010);
      close(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 14'h0020);
      close(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 14'h0030);
      // unmapped place reads zero and ignores writes
      bus(1'b1, 32'h0000_0010, 32'h5);
      bus(1'b0, 32'h0000_0010, 32'h0);
      check(rd, 32'h0);
      results();
   end
endmodule
`default_nettype wire
